// ==== rsc_pkg.sv ====
package rsc_pkg;
  // --------------------------------------------------------------
  // byte layout and rail counts
  // --------------------------------------------------------------
  localparam int RAILS = 5;  // one main rail plus four secondary
  localparam int DATW = 5;  // data field of a control byte
  localparam logic [3:0] BYTE_BITS = 4'h8;  // bits per control byte
  localparam int MAIN_RAIL = 0;  // enable bit of the main rail
  localparam int DRV_A_BIT = 0;  // driver command, sink driver a
  localparam int DRV_B_BIT = 1;  // driver command, sink driver b

  // --------------------------------------------------------------
  // command codes, first-sent bit is cmd_msb
  // --------------------------------------------------------------
  localparam logic [2:0] CMD_UPDATE = 3'h0;  // commit held codes
  localparam logic [2:0] CMD_VOLT_LO = 3'h1;  // main rail voltage
  localparam logic [2:0] CMD_VOLT_HI = 3'h5;  // rail five voltage
  localparam logic [2:0] CMD_DRIVER = 3'h6;  // sink driver states
  localparam logic [2:0] CMD_ENABLE = 3'h7;  // rail enable states

  // --------------------------------------------------------------
  // reset values and slave addresses
  // --------------------------------------------------------------
  localparam logic [4:0] CODE_DEFAULT = 5'h1B;  // code for 2.980 V
  localparam logic [4:0] RAIL_EN_RESET = 5'h01;  // main rail only
  localparam logic [6:0] I2C_ADDR_HIGH = 7'h3F;  // addr_select high
  localparam logic [6:0] I2C_ADDR_LOW = 7'h4F;  // addr_select low

  // --------------------------------------------------------------
  // carriers and enumerations
  // --------------------------------------------------------------
  typedef logic [DATW-1:0] rsc_code_t;  // 0 = 1.800 V .. 31 = 3.300 V
  typedef rsc_code_t [RAILS-1:0] rsc_codes_t;
  typedef struct packed {
    logic [2:0] cmd;  // sent first
    logic [DATW-1:0] data;  // code, selects or enables
  } rsc_byte_t;
  typedef struct packed {
    rsc_codes_t code;  // active voltage code per rail
    logic [RAILS-1:0] rail_enable;  // bit 0 is main_rail
    logic sink_driver_a;  // high = sinking
    logic sink_driver_b;  // high = sinking
  } rsc_rails_t;
  typedef enum logic {PWR_OFF = 1'b0, PWR_ON = 1'b1} rsc_pwr_t;
  typedef enum logic [1:0] {
    I_IDLE = 2'b00,
    I_ADDR = 2'b01,
    I_DATA = 2'b11,
    I_WAIT = 2'b10
  } rsc_i2c_t;
endpackage

// ==== rsc_spi_rx.sv ====
`timescale 1ns/1ps
module rsc_spi_rx (
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic din,
  output logic byte_full,
  output rsc_pkg::rsc_byte_t rx_byte
);
  import rsc_pkg::*;

  // --------------------------------------------------------------
  // bit counter, cleared while chip select is high
  // --------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cnt;  // bits taken this frame
    logic full;  // eighth bit taken, level
  } rsc_link_t;

  rsc_link_t st;  // link state
  rsc_link_t next_st;  // next link state
  logic [7:0] shreg;  // shift register, first bit ends at msb

  // counter saturates, so bits past the eighth are ignored
  always_comb begin
    next_st = st;
    if (st.cnt != BYTE_BITS) begin
      next_st.cnt = st.cnt + 4'h1;
    end
    next_st.full = (next_st.cnt == BYTE_BITS);
  end

  // cs_n high clears the frame; the link clock may stop at any time
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // mode 0: data sampled on rising edges, clock idles low
  always_ff @(posedge spi_clk) begin
    if (st.cnt != BYTE_BITS) begin
      shreg <= {shreg[6:0], din};
    end
  end

  // full is a flop, so the crossing sees no comparator glitch
  assign byte_full = st.full;
  assign rx_byte = rsc_byte_t'(shreg);
endmodule

// ==== rsc_top.sv ====
`timescale 1ns/1ps
//
// Behaviour
// - byte is 3-bit command then 5-bit data
// - voltage write loads holding stage only
// - update command copies held codes to active
// - update per rail or several at once
// - codes reset to the 2.98 V code
// - enables apply at frame end, unbuffered
// - enable bit one turns on, zero off
// - main rail off shuts whole device down
// - after shutdown only wake key restarts
// - spi port is write-only, no read-back
// - spi mode 0, sample on rising edge
// - port ignores bytes while reset output is low
// - i2c slave only, single-byte writes
// - addr_select picks one of two addresses
// - after reset only main rail enabled
// - secondary rails programmable while on or off
// - main rail programmable only while on
// - keep-alive low shuts whole chip down while wake_n is high
// - codes retained through shutdown
// - code maps monotonically to voltage
// - command code decode table
module rsc_top #(
  parameter bit USE_I2C = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_din,
  input wire logic i2c_scl,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe,
  input wire logic addr_select,
  input wire logic wake_n,
  input wire logic keep_alive,
  output rsc_pkg::rsc_rails_t rails,
  output logic reset_out_n,
  output logic device_on
);
  import rsc_pkg::*;

  // --------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------
  if (DATW != RAILS) begin : g_bad_width
    $error("data field must hold one bit per rail");
  end

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    rsc_pwr_t pwr;  // device on or shut down
    rsc_rails_t out;  // active codes, enables, drivers
    rsc_codes_t held;  // holding stage per rail
    logic rst_out_n;  // low while shut down
    logic cs_s1, cs_s2, cs_s3;  // chip select sync and delay
    logic full_s1, full_s2, full_s3;  // byte-full sync and delay
    logic pend;  // whole byte waits for cs_n rise
    rsc_byte_t pbyte;  // that byte
    logic scl_s1, scl_s2, scl_s3;  // i2c clock sync and delay
    logic sda_s1, sda_s2, sda_s3;  // i2c data sync and delay
    logic as_s1, as_s2;  // addr_select sync
    logic wake_s1, wake_s2;  // wake key sync
    logic keep_s1, keep_s2;  // keep-alive sync
    rsc_i2c_t ist;  // i2c phase
    logic [3:0] ibit;  // bits taken in this i2c byte
    logic [7:0] ishift;  // i2c shift register
    logic sda_oe;  // pulling sda low for ack
    logic sda_out;  // level driven when enabled
  } rsc_state_t;

  // idle levels for the synchronisers avoid a false edge at release
  localparam rsc_state_t ST_RESET = '{
    pwr: PWR_ON,
    out: '{code: {RAILS{CODE_DEFAULT}}, rail_enable: RAIL_EN_RESET,
           sink_driver_a: 1'b0, sink_driver_b: 1'b0},
    held: {RAILS{CODE_DEFAULT}},
    rst_out_n: 1'b1,
    cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
    scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
    wake_s1: 1'b1, wake_s2: 1'b1,
    keep_s1: 1'b1, keep_s2: 1'b1,
    ist: I_IDLE,
    default: '0
  };

  rsc_state_t st;  // registered state
  rsc_state_t next_st;  // next state
  logic link_full;  // link domain: byte complete
  rsc_byte_t link_byte;  // link domain: byte, stable while full
  logic spi_exec;  // spi byte executes this cycle
  logic i2c_exec;  // i2c byte executes this cycle
  logic exec_go;  // a byte executes this cycle
  rsc_byte_t exec_b;  // the byte that executes
  logic scl_rise, scl_fall;  // i2c clock edges
  logic i2c_start, i2c_stop;  // i2c bus conditions
  logic addr_hit;  // address byte names this device for write

  // --------------------------------------------------------------
  // link receiver on its own clock
  // --------------------------------------------------------------
  rsc_spi_rx u_spi_rx (
    .spi_clk(spi_clk),
    .cs_n(spi_cs_n),
    .din(spi_din),
    .byte_full(link_full),
    .rx_byte(link_byte)
  );

  // --------------------------------------------------------------
  // command execution, shared by both ports
  // --------------------------------------------------------------
  function automatic rsc_state_t apply_cmd(rsc_state_t s, rsc_byte_t b);
    rsc_state_t r;
    r = s;
    unique case (b.cmd)
      CMD_UPDATE: begin
        // each select bit commits one rail; others keep their code
        for (int i = 0; i < RAILS; i++) begin
          if (b.data[i]) begin
            r.out.code[i] = s.held[i];
          end
        end
      end
      CMD_DRIVER: begin
        // upper three bits are don't-care
        r.out.sink_driver_a = b.data[DRV_A_BIT];
        r.out.sink_driver_b = b.data[DRV_B_BIT];
      end
      CMD_ENABLE: begin
        r.out.rail_enable = b.data;
        if (!b.data[MAIN_RAIL]) begin
          // main rail off: whole device down, codes kept
          r.pwr = PWR_OFF;
          r.out.rail_enable = '0;
          r.out.sink_driver_a = 1'b0;
          r.out.sink_driver_b = 1'b0;
          r.rst_out_n = 1'b0;
        end
      end
      default: begin
        // codes 1..5: holding stage only, rail on or off alike
        r.held[b.cmd - CMD_VOLT_LO] = b.data;
      end
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------
  // port events, decoded from synchronised levels
  // --------------------------------------------------------------
  // the first stages are read only by the second stages
  always_comb begin
    scl_rise = st.scl_s2 && !st.scl_s3;
    scl_fall = !st.scl_s2 && st.scl_s3;
    i2c_start = st.scl_s2 && st.scl_s3 && st.sda_s3 && !st.sda_s2;
    i2c_stop = st.scl_s2 && st.scl_s3 && !st.sda_s3 && st.sda_s2;
    // write only: a read request is not acknowledged
    addr_hit = (st.ishift[7:1] == (st.as_s2 ? I2C_ADDR_HIGH : I2C_ADDR_LOW))
      && !st.ishift[0];
    // serial port is gated by power only, not by reset_out_n
    spi_exec = !USE_I2C && (st.pwr == PWR_ON) && st.pend
      && st.cs_s2 && !st.cs_s3;
    // ninth rising edge of the data byte, with our ack on the bus
    i2c_exec = USE_I2C && (st.pwr == PWR_ON) && (st.ist == I_DATA)
      && scl_rise && (st.ibit == BYTE_BITS) && st.sda_oe;
    exec_go = spi_exec || i2c_exec;
    exec_b = USE_I2C ? rsc_byte_t'(st.ishift) : st.pbyte;
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    next_st = st;
    // synchronisers for pins and the link domain
    next_st.cs_s1 = spi_cs_n;
    next_st.cs_s2 = st.cs_s1;
    next_st.cs_s3 = st.cs_s2;
    next_st.full_s1 = link_full;
    next_st.full_s2 = st.full_s1;
    next_st.full_s3 = st.full_s2;
    next_st.scl_s1 = i2c_scl;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_s3 = st.scl_s2;
    next_st.sda_s1 = i2c_sda_in;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_s3 = st.sda_s2;
    next_st.as_s1 = addr_select;
    next_st.as_s2 = st.as_s1;
    next_st.wake_s1 = wake_n;
    next_st.wake_s2 = st.wake_s1;
    next_st.keep_s1 = keep_alive;
    next_st.keep_s2 = st.keep_s1;

    // a frame that ends short never sets full and is dropped
    if ((st.cs_s2 && !st.cs_s3) || (!st.cs_s2 && st.cs_s3)) begin
      next_st.pend = 1'b0;
    end
    // spi: byte is taken once full has crossed; byte lines are stable
    // by then, so no word-wide crossing is needed; set wins over clear
    if (st.full_s2 && !st.full_s3) begin
      next_st.pend = 1'b1;
      next_st.pbyte = link_byte;
    end

    // i2c slave: listens and acks, never drives the clock
    if (st.pwr != PWR_ON) begin
      next_st.ist = I_IDLE;
      next_st.sda_oe = 1'b0;
    end else if (i2c_start) begin
      next_st.ist = I_ADDR;
      next_st.ibit = '0;
      next_st.sda_oe = 1'b0;
    end else if (i2c_stop) begin
      next_st.ist = I_IDLE;
      next_st.sda_oe = 1'b0;
    end else begin
      if (scl_rise && (st.ist == I_ADDR || st.ist == I_DATA)) begin
        if (st.ibit != BYTE_BITS) begin
          next_st.ishift = {st.ishift[6:0], st.sda_s2};
          next_st.ibit = st.ibit + 4'h1;
        end else begin
          // ninth clock: only one data byte per transaction
          next_st.ibit = '0;
          if (st.ist == I_ADDR) begin
            next_st.ist = st.sda_oe ? I_DATA : I_IDLE;
          end else begin
            next_st.ist = I_WAIT;
          end
        end
      end
      // ack is driven from the fall after bit eight to the next fall
      if (scl_fall) begin
        next_st.sda_oe = (st.ibit == BYTE_BITS) && ((st.ist == I_DATA)
          || (st.ist == I_ADDR && addr_hit));
      end
    end
    next_st.sda_out = 1'b0;

    // command execution while powered
    if (exec_go) begin
      next_st = apply_cmd(next_st, exec_b);
    end

    // power control from the keys; voltage codes are never touched
    if (st.pwr == PWR_ON) begin
      if (st.wake_s2 && !st.keep_s2) begin
        next_st.pwr = PWR_OFF;
        next_st.out.rail_enable = '0;
        next_st.out.sink_driver_a = 1'b0;
        next_st.out.sink_driver_b = 1'b0;
        next_st.rst_out_n = 1'b0;
      end
    end else if (!st.wake_s2) begin
      // restart: main rail on with its old code, rest off
      next_st.pwr = PWR_ON;
      next_st.out.rail_enable = RAIL_EN_RESET;
      next_st.rst_out_n = 1'b1;
    end
  end

  // --------------------------------------------------------------
  // state register; ce low freezes it unless rst_n is low
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops; spi has no return path
  assign rails = st.out;
  assign reset_out_n = st.rst_out_n;
  assign device_on = (st.pwr == PWR_ON);
  assign i2c_sda_oe = st.sda_oe;
  assign i2c_sda_out = st.sda_out;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_exec(logic [2:0] c);
    ce && exec_go && (exec_b.cmd == c);
  endsequence
  sequence s_off_wake;
    ce && (st.pwr == PWR_OFF) && !st.wake_s2;
  endsequence
  // keep-alive shutdown outranks a command in the same cycle
  sequence s_key_quiet;
    st.wake_s2 || st.keep_s2;
  endsequence

  a_reset_defaults: assert property ($rose(rst_n) |->
    (rails.code == {RAILS{CODE_DEFAULT}}) && (rails.rail_enable == RAIL_EN_RESET))
    else $error("reset values of codes or enables wrong");
  a_hold_only: assert property (
    ce && exec_go && (exec_b.cmd >= CMD_VOLT_LO) && (exec_b.cmd <= CMD_VOLT_HI)
    |=> $stable(rails.code) && (st.held[$past(exec_b.cmd) - CMD_VOLT_LO]
    == $past(exec_b.data)))
    else $error("voltage write reached active code");
  a_update_sel: assert property (s_exec(CMD_UPDATE) |=>
    rails.code[0] == ($past(exec_b.data[0]) ? $past(st.held[0]) : $past(st.out.code[0])))
    else $error("update commit wrong for main rail");
  a_enable_now: assert property (s_exec(CMD_ENABLE) ##0 exec_b.data[MAIN_RAIL]
    ##0 s_key_quiet |=> rails.rail_enable == $past(exec_b.data))
    else $error("enable bits not applied");
  a_main_off_shut: assert property (s_exec(CMD_ENABLE) ##0 !exec_b.data[MAIN_RAIL]
    |=> !device_on && (rails.rail_enable == '0) && !reset_out_n)
    else $error("main rail off did not shut down");
  a_driver_bits: assert property (s_exec(CMD_DRIVER) ##0 s_key_quiet |=>
    (rails.sink_driver_a == $past(exec_b.data[DRV_A_BIT]))
    && (rails.sink_driver_b == $past(exec_b.data[DRV_B_BIT])) && $stable(rails.rail_enable))
    else $error("driver command wrong");
  a_off_ignores: assert property ((st.pwr == PWR_OFF) |-> !exec_go)
    else $error("command executed while shut down");
  a_wake_restart: assert property (s_off_wake |=>
    device_on && (rails.rail_enable == RAIL_EN_RESET) && !rails.sink_driver_a)
    else $error("wake did not restart correctly");
  a_keep_alive_off: assert property (
    ce && device_on && st.wake_s2 && !st.keep_s2 && !exec_go |=> !device_on)
    else $error("keep-alive low did not shut down");
  a_codes_kept: assert property ((st.pwr == PWR_OFF) |=> $stable(rails.code))
    else $error("codes changed during shutdown");
  a_i2c_ack: assert property (
    ce && (st.pwr == PWR_ON) && !i2c_start && !i2c_stop && scl_fall
    && (st.ist == I_ADDR) && (st.ibit == BYTE_BITS) |=> i2c_sda_oe == $past(addr_hit))
    else $error("address ack wrong");
endmodule

// ==== rsc_host.sv ====
`timescale 1ns/1ps
// --------------------------------------------------------------
// spi and i2c host model, spi mode 0, write only
// --------------------------------------------------------------
module rsc_host (
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_din,
  output logic i2c_scl,
  output logic i2c_sda_m,
  input logic i2c_sda
);
  import rsc_pkg::*;

  // serial clock parked low between frames, port idle
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_din = 1'b0;
    i2c_scl = 1'b1;  // i2c bus idle, both lines released
    i2c_sda_m = 1'b1;
  end

  // --------------------------------------------------------------
  // one frame, cmd_msb first; n below eight aborts the byte early
  // --------------------------------------------------------------
  // no spi input pin here: the port never returns data
  task automatic frame(input logic [7:0] b, input int n);
    #3;  // phase offset, unrelated to clk_sys
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_din = b[7-i];
      #16;
      spi_clk = 1'b1;
      #16;
      spi_clk = 1'b0;
    end
    // cs rise held off so the synced full flag lands first
    #60;
    spi_cs_n = 1'b1;
    // released line shows the inverse, never a stale bit
    spi_din = ~spi_din;
  endtask

  // --------------------------------------------------------------
  // one i2c write: start, address with write bit, data, stop
  // --------------------------------------------------------------
  // ack slots release sda; the ack is read late in the high phase,
  // long after the slave's synchronised reaction to the fall
  task automatic i2c_write(input logic [6:0] a, input logic [7:0] d,
      output logic ack_a, output logic ack_d);
    logic [17:0] bits;  // address, write bit, ack, data, ack
    bits = {a, 1'b0, 1'b1, d, 1'b1};
    ack_a = 1'b0;
    ack_d = 1'b0;
    #7;
    i2c_sda_m = 1'b0;  // start: sda falls while scl is high
    #80;
    for (int i = 17; i >= 0; i--) begin
      i2c_scl = 1'b0;
      #40;
      i2c_sda_m = bits[i];
      #40;
      i2c_scl = 1'b1;
      #80;
      if (i == 9) begin
        ack_a = !i2c_sda;
      end
      if (i == 0) begin
        ack_d = !i2c_sda;
      end
    end
    // stop: sda rises while scl is high
    i2c_scl = 1'b0;
    #40;
    i2c_sda_m = 1'b0;
    #40;
    i2c_scl = 1'b1;
    #80;
    i2c_sda_m = 1'b1;
    #80;
  endtask
endmodule

// ==== test_rsc_top.sv ====
`timescale 1ns/1ps
// --------------------------------------------------------------
// command decoder bench, spi and i2c variants
// --------------------------------------------------------------
module test_rsc_top;
  import rsc_pkg::*;

  logic clk_sys;  // 100 MHz system clock
  logic rst_n;  // synchronous reset
  logic ce;  // clock enable, low only in the keep-alive test
  logic wake_n;  // wake key, active low
  logic keep_alive;  // keep-alive pin
  logic spi_clk;  // link clock from host model
  logic spi_cs_n;
  logic spi_din;
  rsc_rails_t rails;  // active outputs
  logic reset_out_n;
  logic device_on;
  rsc_rails_t exp;  // expected rail state
  int n_mismatch;
  int cmp_count;
  logic [4:0] en_list [3];  // enable patterns, main bit always set
  logic i2c_scl;  // i2c clock from host model
  logic i2c_sda_m;  // host's own sda drive, high = released
  logic i2c_sda;  // wired bus level, pulled up
  logic i2c_sda_oe;
  logic i2c_sda_out;
  logic as_pin;  // addr_select of the i2c decoder
  logic ack_a, ack_d;  // acks seen by the host
  rsc_rails_t rails2;  // i2c decoder outputs
  rsc_rails_t exp2;
  logic reset2_n;
  logic on2;

  // open-drain bus: either side may pull low
  assign i2c_sda = i2c_sda_m && !(i2c_sda_oe && !i2c_sda_out);

  // free-running system clock
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  rsc_host host (
    .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n),
    .spi_din(spi_din),
    .i2c_scl(i2c_scl),
    .i2c_sda_m(i2c_sda_m),
    .i2c_sda(i2c_sda)
  );

  // i2c pins idle high: the spi variant ignores them
  rsc_top dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n),
    .spi_din(spi_din),
    .i2c_scl(1'b1),
    .i2c_sda_in(1'b1),
    .i2c_sda_out(),
    .i2c_sda_oe(),
    .addr_select(1'b1),
    .wake_n(wake_n),
    .keep_alive(keep_alive),
    .rails(rails),
    .reset_out_n(reset_out_n),
    .device_on(device_on)
  );

  // second decoder on the i2c port; its spi pins are parked
  rsc_top #(.USE_I2C(1'b1)) dut_i2c (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .spi_clk(1'b0),
    .spi_cs_n(1'b1),
    .spi_din(1'b0),
    .i2c_scl(i2c_scl),
    .i2c_sda_in(i2c_sda),
    .i2c_sda_out(i2c_sda_out),
    .i2c_sda_oe(i2c_sda_oe),
    .addr_select(as_pin),
    .wake_n(wake_n),
    .keep_alive(keep_alive),
    .rails(rails2),
    .reset_out_n(reset2_n),
    .device_on(on2)
  );

  // --------------------------------------------------------------
  // shared helpers
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  // rails against model, plus power state; settled one step past the edge
  task automatic check_all(input logic on);
    #1;
    chk("rails", rails, exp);
    chk("device_on", {31'h0000_0000, device_on}, {31'h0000_0000, on});
    chk("reset_out_n", {31'h0000_0000, reset_out_n}, {31'h0000_0000, on});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // answer lands 2-3 cycles after cs rise; ten is a safe bound
  task automatic send(input logic [7:0] b, input int n = 8);
    host.frame(b, n);
    wait_cyc(10);
  endtask

  // wake key pressed briefly while off
  task automatic wake;
    @(posedge clk_sys);
    wake_n <= 1'b0;
    wait_cyc(5);
    wake_n <= 1'b1;
    wait_cyc(10);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the whole sequence
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    ce = 1'b1;
    rst_n = 1'b0;
    wake_n = 1'b1;
    keep_alive = 1'b1;
    en_list = '{5'h1F, 5'h15, 5'h0B};
    exp = '{code: {5{CODE_DEFAULT}}, rail_enable: RAIL_EN_RESET,
            sink_driver_a: 1'b0, sink_driver_b: 1'b0};
    exp2 = exp;
    as_pin = 1'b1;
    wait_cyc(5);
    rst_n <= 1'b1;
    wait_cyc(3);
    check_all(1'b1);
    $display("test reset done");

    // i2c variant: slave acks only its own address, then executes
    host.i2c_write(I2C_ADDR_HIGH, {CMD_ENABLE, 5'h03}, ack_a, ack_d);
    wait_cyc(2);
    #1;
    exp2.rail_enable = 5'h03;
    chk("i2c addr ack", {31'h0000_0000, ack_a}, 32'h0000_0001);
    chk("i2c data ack", {31'h0000_0000, ack_d}, 32'h0000_0001);
    chk("i2c rails", rails2, exp2);
    host.i2c_write(I2C_ADDR_LOW, {CMD_ENABLE, 5'h07}, ack_a, ack_d);
    wait_cyc(2);
    #1;
    chk("i2c foreign ack", {31'h0000_0000, ack_a}, 32'h0000_0000);
    chk("i2c rails", rails2, exp2);
    @(posedge clk_sys);
    as_pin <= 1'b0;
    wait_cyc(4);
    host.i2c_write(I2C_ADDR_LOW, {CMD_DRIVER, 5'h01}, ack_a, ack_d);
    wait_cyc(2);
    #1;
    exp2.sink_driver_a = 1'b1;
    chk("i2c low addr ack", {31'h0000_0000, ack_a}, 32'h0000_0001);
    chk("i2c rails", rails2, exp2);
    chk("i2c device_on", {31'h0000_0000, on2}, 32'h0000_0001);
    chk("i2c reset_out_n", {31'h0000_0000, reset2_n}, 32'h0000_0001);
    $display("test i2c done");

    // held codes stay hidden until a selective update
    send({3'h2, 5'h05});
    check_all(1'b1);
    send({CMD_UPDATE, 5'h02});
    exp.code[1] = 5'h05;
    check_all(1'b1);
    send({3'h3, 5'h00});
    send({3'h4, 5'h1F});
    check_all(1'b1);
    send({CMD_UPDATE, 5'h0C});
    exp.code[2] = 5'h00;
    exp.code[3] = 5'h1F;
    check_all(1'b1);
    send({CMD_VOLT_LO, 5'h11});
    send({CMD_UPDATE, 5'h01});
    exp.code[0] = 5'h11;
    check_all(1'b1);
    $display("test voltage done");

    // enables and drivers bypass the holding stage
    foreach (en_list[i]) begin
      send({CMD_ENABLE, en_list[i]});
      exp.rail_enable = en_list[i];
      check_all(1'b1);
    end
    send({CMD_DRIVER, 5'h1D});
    exp.sink_driver_a = 1'b1;
    check_all(1'b1);
    send({CMD_DRIVER, 5'h02});
    exp.sink_driver_a = 1'b0;
    exp.sink_driver_b = 1'b1;
    check_all(1'b1);
    send({CMD_ENABLE, 5'h1F}, 5);
    check_all(1'b1);
    $display("test enable done");

    // rail five is off here yet still takes a new code
    send({CMD_VOLT_HI, 5'h07});
    send({CMD_UPDATE, 5'h10});
    exp.code[4] = 5'h07;
    check_all(1'b1);
    $display("test program off rail done");

    // soft shutdown, port dead, wake restores main rail only
    send({CMD_ENABLE, 5'h1E});
    exp.rail_enable = 5'h00;
    exp.sink_driver_b = 1'b0;
    check_all(1'b0);
    send({CMD_ENABLE, 5'h1F});
    send({CMD_VOLT_LO, 5'h00});
    send({CMD_UPDATE, 5'h1F});
    check_all(1'b0);
    wake();
    exp.rail_enable = 5'h01;
    check_all(1'b1);
    $display("test soft shutdown done");

    // keep-alive pin low shuts the whole chip down, but not while frozen
    @(posedge clk_sys);
    ce <= 1'b0;
    keep_alive <= 1'b0;
    wait_cyc(10);
    check_all(1'b1);
    @(posedge clk_sys);
    ce <= 1'b1;
    wait_cyc(10);
    exp.rail_enable = 5'h00;
    check_all(1'b0);
    @(posedge clk_sys);
    keep_alive <= 1'b1;
    wake();
    exp.rail_enable = 5'h01;
    check_all(1'b1);
    send({CMD_ENABLE, 5'h03});
    exp.rail_enable = 5'h03;
    check_all(1'b1);
    $display("test keep alive done");
    report_and_stop();
  end
endmodule
